// ===== rtl/anps_top.sv
// Next page exchange registers behind a management serial slave
`timescale 1ns/1ps
`include "anps_params.svh"

module anps_top #(
   parameter logic [4:0] PHY_ADDR = `ANPS_PHY_ADDR_DEF
) (
   input  wire logic              clk,
   input  wire logic              rst_b,
   input  wire logic              mdc,
   input  wire logic              mdio_in,
   output logic                   mdio_out,
   output logic                   mdio_oe,
   input  wire logic              manual_mode,
   input  wire logic              an_restart,
   input  wire logic              local_np_able,
   input  wire anps_pkg::anps_page_s page_in,
   input  wire logic              ext_event,
   output logic [15:0]            np_tx_page,
   output logic                   np_exchange_en
);
   import anps_pkg::*;

   // ****************************************
   // Pin synchronisers
   // ****************************************
   logic [1:0] mdc_sync;
   logic [1:0] mdio_sync;
   logic [1:0] man_sync;
   logic       mdc_prev;
   logic       mdc_rise;

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         mdc_sync  <= 2'h0;
         mdio_sync <= 2'h3;
         man_sync  <= 2'h0;
         mdc_prev  <= 1'b0;
      end else begin
         mdc_sync  <= {mdc_sync[0], mdc};
         mdio_sync <= {mdio_sync[0], mdio_in};
         man_sync  <= {man_sync[0], manual_mode};
         mdc_prev  <= mdc_sync[1];
      end
   end

   assign mdc_rise = mdc_sync[1] & ~mdc_prev;

   // ****************************************
   // Page registers
   // ****************************************
   logic [15:0] base_rx;
   logic [15:0] np_rx;
   logic        stat_page_rx;
   logic        stat_np_able;
   logic        stat_base;
   logic        ext_bit;
   logic        partner_np;
   logic        rd_clear6;
   logic        wr_fire;
   logic [4:0]  wr_reg;
   logic [15:0] wr_data;

   function automatic logic addr_hit(input logic [4:0] a,
                                     input logic [4:0] b);
      addr_hit = (a == b);
   endfunction

   // Received pages land in base or next page register
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         base_rx   <= 16'h0000;
         np_rx     <= 16'h0000;
         stat_base <= 1'b0;
      end else if (page_in.valid) begin
         if (page_in.is_base) begin
            base_rx <= page_in.data;
         end else begin
            np_rx <= page_in.data;
         end
         stat_base <= page_in.is_base;
      end
   end

   // Latched flags; a new event beats the read clear
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         stat_page_rx <= 1'b0;
      end else if (page_in.valid) begin
         stat_page_rx <= 1'b1;
      end else if (rd_clear6) begin
         stat_page_rx <= 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         ext_bit <= 1'b0;
      end else if (ext_event) begin
         ext_bit <= 1'b1;
      end else if (rd_clear6) begin
         ext_bit <= 1'b0;
      end
   end

   // Partner ability seen in a base page's next page bit
   logic np_seen;
   assign np_seen = page_in.valid & page_in.is_base
                    & page_in.data[`ANPS_BIT_NEXT_PAGE];

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         stat_np_able <= 1'b0;
         partner_np   <= 1'b0;
      end else if (np_seen) begin
         stat_np_able <= 1'b1;
         partner_np   <= 1'b1;
      end else if (an_restart) begin
         stat_np_able <= 1'b0;
         partner_np   <= 1'b0;
      end else if (rd_clear6) begin
         stat_np_able <= 1'b0;
      end
   end

   // Next page phase only when both ends advertise it
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         np_exchange_en <= 1'b0;
      end else begin
         np_exchange_en <= local_np_able & partner_np;
      end
   end

   // Outgoing page; reset value is the message page word
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         np_tx_page <= `ANPS_NP_TX_RESET;
      end else if (wr_fire && !man_sync[1]
                   && addr_hit(wr_reg, `ANPS_ADDR_NP_TX)) begin
         np_tx_page <= wr_data;
      end
   end

   // ****************************************
   // Read mux
   // ****************************************
   logic [15:0] status6;
   logic [15:0] rd_mux;

   always_comb begin
      status6 = 16'h0000;
      status6[`ANPS_BIT_PAGE_RX]   = stat_page_rx;
      status6[`ANPS_BIT_NP_ABLE]   = stat_np_able;
      status6[`ANPS_BIT_BASE_PAGE] = stat_base;
   end

   always_comb begin
      rd_mux = 16'h0000;
      if (addr_hit(wr_reg, `ANPS_ADDR_BASE_RX)) begin
         rd_mux = base_rx;
      end else if (addr_hit(wr_reg, `ANPS_ADDR_STATUS)) begin
         rd_mux = status6;
      end else if (addr_hit(wr_reg, `ANPS_ADDR_NP_TX)) begin
         rd_mux = np_tx_page;
      end else if (addr_hit(wr_reg, `ANPS_ADDR_NP_RX)) begin
         rd_mux = np_rx;
      end else if (addr_hit(wr_reg, `ANPS_ADDR_EXT_STAT)) begin
         rd_mux = {14'h0000, ext_bit, 1'b0};
      end
   end

   // ****************************************
   // Management frame slave
   // ****************************************
   anps_state_e state;
   logic [5:0]  pre_cnt;
   logic [4:0]  bit_cnt;
   logic [12:0] hdr;
   logic [15:0] shreg;
   logic        is_read;
   logic        is_mine;
   logic        bit_in;

   assign bit_in = mdio_sync[1];
   assign wr_reg = hdr[4:0];

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         state     <= ANPS_PRE;
         pre_cnt   <= 6'h00;
         bit_cnt   <= 5'h00;
         hdr       <= 13'h0000;
         shreg     <= 16'h0000;
         is_read   <= 1'b0;
         is_mine   <= 1'b0;
         mdio_out  <= 1'b1;
         mdio_oe   <= 1'b0;
         rd_clear6 <= 1'b0;
         wr_fire   <= 1'b0;
         wr_data   <= 16'h0000;
      end else begin
         rd_clear6 <= 1'b0;
         wr_fire   <= 1'b0;
         if (mdc_rise) begin
            unique case (state)
               ANPS_PRE: begin
                  mdio_oe <= 1'b0;
                  if (bit_in) begin
                     if (pre_cnt != `ANPS_PREAMBLE_LEN) begin
                        pre_cnt <= pre_cnt + 6'h01;
                     end
                  end else if (pre_cnt == `ANPS_PREAMBLE_LEN) begin
                     state   <= ANPS_HDR;
                     bit_cnt <= 5'h00;
                  end else begin
                     pre_cnt <= 6'h00;
                  end
               end
               ANPS_HDR: begin
                  hdr     <= {hdr[11:0], bit_in};
                  bit_cnt <= bit_cnt + 5'h01;
                  if (bit_cnt == `ANPS_HDR_BITS - 5'h01) begin
                     state   <= ANPS_TA;
                     bit_cnt <= 5'h00;
                  end
               end
               ANPS_TA: begin
                  if (bit_cnt == 5'h00) begin
                     is_mine <= hdr[12] && addr_hit(hdr[9:5], PHY_ADDR);
                     is_read <= hdr[11:10] == `ANPS_OP_READ;
                     if (hdr[12] && addr_hit(hdr[9:5], PHY_ADDR)
                         && hdr[11:10] == `ANPS_OP_READ) begin
                        // Snapshot first, clear after
                        shreg    <= rd_mux;
                        mdio_oe  <= 1'b1;
                        mdio_out <= 1'b0;
                        rd_clear6 <= addr_hit(wr_reg,
                                              `ANPS_ADDR_STATUS);
                     end
                     bit_cnt <= 5'h01;
                  end else begin
                     state   <= ANPS_DATA;
                     bit_cnt <= 5'h00;
                     if (is_read && is_mine) begin
                        mdio_out <= shreg[15];
                        shreg    <= {shreg[14:0], 1'b0};
                     end
                  end
               end
               ANPS_DATA: begin
                  bit_cnt <= bit_cnt + 5'h01;
                  if (is_read && is_mine) begin
                     mdio_out <= shreg[15];
                     shreg    <= {shreg[14:0], 1'b0};
                  end else begin
                     wr_data <= {wr_data[14:0], bit_in};
                  end
                  if (bit_cnt == `ANPS_DATA_BITS - 5'h01) begin
                     state    <= ANPS_PRE;
                     pre_cnt  <= 6'h00;
                     mdio_oe  <= 1'b0;
                     mdio_out <= 1'b1;
                     wr_fire  <= is_mine
                                 && hdr[11:10] == `ANPS_OP_WRITE;
                  end
               end
            endcase
         end
      end
   end

   // ****************************************
   // Checks
   // ****************************************
   a_page_flag_set: assert property (@(posedge clk) disable iff (!rst_b)
      page_in.valid |=> stat_page_rx)
      else $error("page received flag not set");
   a_base_ind: assert property (@(posedge clk) disable iff (!rst_b)
      page_in.valid |=> stat_base == $past(page_in.is_base))
      else $error("base page indicator wrong");
   a_read_clears: assert property (@(posedge clk) disable iff (!rst_b)
      rd_clear6 && !page_in.valid && !ext_event
      |=> !stat_page_rx && !ext_bit)
      else $error("read of status did not clear");
   a_restart_clear: assert property (@(posedge clk) disable iff (!rst_b)
      an_restart && !np_seen |=> !stat_np_able ##1 !np_exchange_en)
      else $error("partner ability survived restart");
   a_np_gate: assert property (@(posedge clk) disable iff (!rst_b)
      !local_np_able |=> !np_exchange_en)
      else $error("next page phase without local ability");
   a_manual_block: assert property (@(posedge clk) disable iff (!rst_b)
      wr_fire && man_sync[1] |=> $stable(np_tx_page))
      else $error("write accepted in manual mode");
   a_tx_write: assert property (@(posedge clk) disable iff (!rst_b)
      wr_fire && !man_sync[1] && wr_reg == `ANPS_ADDR_NP_TX
      |=> np_tx_page == $past(wr_data))
      else $error("transmit page not written");
   a_read_snap: assert property (@(posedge clk) disable iff (!rst_b)
      rd_clear6 |-> shreg == $past(status6))
      else $error("read data not taken before clear");

   c_read_status: cover property (@(posedge clk) rd_clear6);
   c_write_tx:    cover property (@(posedge clk) wr_fire && !man_sync[1]);
   c_np_phase:    cover property (@(posedge clk) np_exchange_en);
   c_set_on_clr:  cover property (@(posedge clk) rd_clear6 && page_in.valid);

endmodule

// ===== rtl/anps_params.svh
// Constants for the next page exchange register block
// Function
// - Standard auto-negotiation with optional next pages
// - Transmit page from reg 7, receive into 8
// - Next pages only when both sides able
// - Page received bit 6.1 latches until read
// - Partner able 6.2 latches, clears on restart
// - Bit 6.5 shows held page is base
// - Reading reg 6 clears 6.1, 6.2 and 16.1
// - Next page word layout, message code 5
// - Manual mode ignores management writes
`ifndef ANPS_PARAMS_SVH
`define ANPS_PARAMS_SVH

// ****************************************
// Register addresses
// ****************************************
`define ANPS_ADDR_BASE_RX   5'h05
`define ANPS_ADDR_STATUS    5'h06
`define ANPS_ADDR_NP_TX     5'h07
`define ANPS_ADDR_NP_RX     5'h08
`define ANPS_ADDR_EXT_STAT  5'h10

// ****************************************
// Field positions
// ****************************************
`define ANPS_BIT_PAGE_RX    1
`define ANPS_BIT_NP_ABLE    2
`define ANPS_BIT_BASE_PAGE  5
`define ANPS_BIT_EXT_EVT    1
`define ANPS_BIT_NEXT_PAGE  15

// ****************************************
// Reset values
// ****************************************
`define ANPS_NP_TX_RESET    16'hA005
`define ANPS_PHY_ADDR_DEF   5'h00

// ****************************************
// Management frame timing, in clock edges of the management clock, and opcodes
// ****************************************
`define ANPS_PREAMBLE_LEN   6'h20
`define ANPS_HDR_BITS       5'h0D
`define ANPS_DATA_BITS      5'h10
`define ANPS_OP_READ        2'h2
`define ANPS_OP_WRITE       2'h1

`endif

// ===== rtl/anps_pkg.sv
// Types shared by the next page exchange register block
package anps_pkg;

   // Page arriving from the negotiation engine
   typedef struct packed {
      logic        valid;
      logic        is_base;
      logic [15:0] data;
   } anps_page_s;

   // Management frame states
   typedef enum logic [3:0] {
      ANPS_PRE  = 4'h1,
      ANPS_HDR  = 4'h2,
      ANPS_TA   = 4'h4,
      ANPS_DATA = 4'h8
   } anps_state_e;

endpackage

// ===== sim/anps_mgmt_model.sv
// Station management master model for the serial pins
`timescale 1ns/1ps
module anps_mgmt_model #(
   parameter int H = 5
) (
   input  wire logic clk,
   output logic      mdc,
   output logic      mdio_in,
   input  wire logic mdio_out,
   input  wire logic mdio_oe
);
   logic m_oe = 1'b0;
   logic m_o  = 1'b1;
   logic s;
   // Pull-up holds the released line high
   assign mdio_in = m_oe ? m_o : (mdio_oe ? mdio_out : 1'b1);
   initial mdc = 1'b0;
   // *****
   // One bit; sampled at the rise, held a full period
   // *****
   task bt(input logic v, input logic dr);
      @(posedge clk) #1;
      m_oe = dr;
      m_o = v;
      repeat (H) @(posedge clk);
      #1 mdc = 1'b1;
      s = mdio_in;
      repeat (H) @(posedge clk);
      #1 mdc = 1'b0;
   endtask
   task frame(input logic [1:0] op, input logic [4:0] pa,
              input logic [4:0] ra, input logic [15:0] wd,
              output logic [15:0] rd);
      logic [12:0] h;
      logic        w;
      // Second start bit, opcode, port address, register address
      h = {1'b1, op, pa, ra};
      w = (op == 2'h1);
      repeat (32) bt(1'b1, 1'b1);
      bt(1'b0, 1'b1);
      for (int i = 12; i >= 0; i--) bt(h[i], 1'b1);
      bt(1'b1, w);
      bt(1'b0, w);
      for (int i = 15; i >= 0; i--) begin
         bt(wd[i], w);
         rd[i] = s;
      end
      @(posedge clk) #1;
      m_oe = 1'b0;
      repeat (8) @(posedge clk);
      // Hand back off the edge so callers never race the clock
      #1;
   endtask
endmodule

// ===== sim/testbench.sv
// Self-checking bench for the next page exchange registers
`timescale 1ns/1ps
module testbench;
   import anps_pkg::*;
   logic        clk = 1'b0;
   logic        rst_b = 1'b0;
   logic        mdc;
   logic        mdio_in;
   logic        mdio_out;
   logic        mdio_oe;
   logic        manual_mode = 1'b0;
   logic        an_restart = 1'b0;
   logic        local_np_able = 1'b0;
   anps_page_s  page_in = '0;
   logic        ext_event = 1'b0;
   logic [15:0] np_tx_page;
   logic        np_exchange_en;
   logic [15:0] rd;
   logic [15:0] w;
   logic [15:0] d;
   logic        b;
   int          fails = 0;
   int          tests_run = 0;

   always #4 clk = ~clk;

   anps_top dut (.clk(clk), .rst_b(rst_b), .mdc(mdc),
      .mdio_in(mdio_in), .mdio_out(mdio_out), .mdio_oe(mdio_oe),
      .manual_mode(manual_mode), .an_restart(an_restart),
      .local_np_able(local_np_able), .page_in(page_in),
      .ext_event(ext_event), .np_tx_page(np_tx_page),
      .np_exchange_en(np_exchange_en));
   anps_mgmt_model sm (.clk(clk), .mdc(mdc), .mdio_in(mdio_in),
      .mdio_out(mdio_out), .mdio_oe(mdio_oe));

   // *****
   // Expectations and bus tasks
   // *****
   function logic [15:0] st6(logic p, logic a, logic bp);
      return {10'h000, bp, 2'b00, a, p, 1'b0};
   endfunction
   function logic [15:0] npw(logic ack, logic tog);
      return {1'b1, ack, 1'b1, 1'b0, tog, 11'h005};
   endfunction
   task chk(input logic [15:0] seen, input logic [15:0] exp);
      tests_run++;
      if (seen !== exp) begin
         fails++;
         $display("Error at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task rdr(input logic [4:0] a, input logic [15:0] e);
      sm.frame(2'h2, 5'h00, a, 16'h0000, rd);
      chk(rd, e);
   endtask
   task wr(input logic [4:0] a, input logic [15:0] v);
      sm.frame(2'h1, 5'h00, a, v, rd);
   endtask
   task pg(input logic bp, input logic [15:0] v);
      @(posedge clk) #1;
      page_in = '{1'b1, bp, v};
      @(posedge clk) #1;
      page_in.valid = 1'b0;
      repeat (3) @(posedge clk);
      #1;
   endtask
   task end_of_test;
      $display("Checks %0d, mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   initial begin
      repeat (60000) @(posedge clk);
      fails++;
      end_of_test();
   end

   initial begin
      w = $urandom(47);
      repeat (20) @(posedge clk);
      #1 rst_b = 1'b1;
      repeat (4) @(posedge clk);
      chk(np_tx_page, npw(1'b0, 1'b0));
      rdr(5'h07, 16'hA005);
      rdr(5'h06, st6(1'b0, 1'b0, 1'b0));
      for (int i = 0; i < 2; i++) begin
         w = npw(1'($urandom), 1'($urandom));
         wr(5'h07, w);
         chk(np_tx_page, w);
      end
      rdr(5'h07, w);
      manual_mode = 1'b1;
      wr(5'h07, ~w);
      chk(np_tx_page, w);
      manual_mode = 1'b0;
      sm.frame(2'h1, 5'h01, 5'h07, ~w, rd);
      chk(np_tx_page, w);
      sm.frame(2'h2, 5'h01, 5'h07, 16'h0000, rd);
      chk(rd, 16'hFFFF);
      rdr(5'h09, 16'h0000);
      local_np_able = 1'b1;
      for (int i = 0; i < 4; i++) begin
         b = 1'($urandom);
         d = 16'($urandom);
         pg(b, d);
         rdr(b ? 5'h05 : 5'h08, d);
         rdr(5'h06, st6(1'b1, b & d[15], b));
         rdr(5'h06, st6(1'b0, 1'b0, b));
      end
      pg(1'b1, 16'h8000);
      chk({15'h0000, np_exchange_en}, 16'h0001);
      pg(1'b0, ~w);
      wr(5'h08, w);
      rdr(5'h08, ~w);
      @(posedge clk) #1 ext_event = 1'b1;
      @(posedge clk) #1 ext_event = 1'b0;
      rdr(5'h10, 16'h0002);
      rdr(5'h06, st6(1'b1, 1'b1, 1'b0));
      rdr(5'h10, 16'h0000);
      pg(1'b1, 16'h8000);
      @(posedge clk) #1 an_restart = 1'b1;
      @(posedge clk) #1 an_restart = 1'b0;
      repeat (3) @(posedge clk);
      chk({15'h0000, np_exchange_en}, 16'h0000);
      rdr(5'h06, st6(1'b1, 1'b0, 1'b1));
      // Base page seen again: software reloads its next page
      wr(5'h07, npw(1'b0, 1'b1));
      chk(np_tx_page, npw(1'b0, 1'b1));
      local_np_able = 1'b0;
      pg(1'b1, 16'h8000);
      chk({15'h0000, np_exchange_en}, 16'h0000);
      end_of_test();
   end
endmodule
